/* hdl/result_hold.sv */
// Holds one conversion result until the next load.
// Assumes load is a one-cycle pulse on the same clock.
`default_nettype none

module result_hold #(
   parameter int W = 10
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // Load side
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   // Held result
   output logic      [W-1:0] data
);

   typedef struct packed {
      logic [W-1:0] data;
   } state_s;

   state_s r;
   state_s next_r;

   always_comb begin
      next_r = r;
      if (load) begin
         next_r.data = value;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign data = r.data;

   hold_value_a: assert property (@(posedge clock) disable iff (!rst_n)
      !load |=> (data == $past(data)))
      else $error("result changed without a load");

endmodule

`default_nettype wire

/* hdl/status_flags.sv */
// Sticky event flags; a set in the same cycle as a clear wins.
// Assumes set and clear come from logic on the same clock.
`default_nettype none

module status_flags #(
   parameter int W = 32
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // Events and clears
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clear,
   // Flags
   output logic      [W-1:0] flags
);

   typedef struct packed {
      logic [W-1:0] flags;
   } state_s;

   state_s r;
   state_s next_r;

   always_comb begin
      next_r       = r;
      // A late event must not be lost to a clear
      next_r.flags = (r.flags & ~clear) | set;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign flags = r.flags;

   set_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
      (|set) |=> ((flags & $past(set)) == $past(set)))
      else $error("event lost against a clear");

endmodule

`default_nettype wire

/* hdl/touch_regs.sv */
// Register bank of the touch-screen converter: results, interrupt mask,
// status flags, panel switch commands and keyed write guard.
// Assumes converter events are one-cycle pulses on the same clock.
// How it works
// - last result loads on every conversion
// - enable-register ones set mask bits
// - disable-register ones clear mask bits
// - mask view reads enabled sources
// - one shared bit layout for all three
// - X result in low ten bits
// - first pressure result in low ten
// - second pressure result in low ten
// - four switch bits close or open switches
// - guard bit changes only with key
// - guarded config writes rejected while active
// - status bit zero shows guard active
// - status upper field holds rejected offset
// - overrun and pen flags clear on read
// - ready flag clears on last-result read
`default_nettype none

module touch_regs
   import touch_regs_pkg::*;
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // Register port
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [DATA_W-1:0]   wr_data,
   input  wire logic                wr_strobe,
   input  wire logic                rd_strobe,
   output logic      [DATA_W-1:0]   rd_data,
   // Converter events
   input  wire logic [CHAN_N-1:0]   channel_done,
   input  wire logic                x_done,
   input  wire logic                pressure_one_done,
   input  wire logic                pressure_two_done,
   input  wire logic [RESULT_W-1:0] conv_value,
   input  wire logic                pen_touch,
   input  wire logic                pen_lift,
   input  wire logic                receive_count_end,
   input  wire logic                receive_both_empty,
   // Configuration to the converter
   output logic      [DATA_W-1:0]   converter_mode,
   output logic      [DATA_W-1:0]   trigger_setup,
   output logic      [DATA_W-1:0]   touch_setup,
   // Panel switches
   output logic                     x_plus_switch,
   output logic                     x_minus_switch,
   output logic                     y_plus_switch,
   output logic                     y_minus_switch,
   // Interrupt
   output logic                     irq
);

   typedef struct packed {
      logic                guard_en;
      logic [ERR_W-1:0]    err_off;
      logic [DATA_W-1:0]   mask;
      logic [SWITCH_W-1:0] switches;
      logic [DATA_W-1:0]   mode_cfg;
      logic [DATA_W-1:0]   trig_cfg;
      logic [DATA_W-1:0]   touch_cfg;
      logic [DATA_W-1:0]   rdata;
      logic                irq;
   } regs_s;

   regs_s r;
   regs_s next_r;

   // X, first and second pressure form one done group and one overrun group
   localparam int XZ_N = 3;

   logic [DATA_W-1:0]   flags;
   logic [DATA_W-1:0]   flag_set;
   logic [DATA_W-1:0]   flag_clr;
   logic [DATA_W-1:0]   status;
   logic [RES_N-1:0]    res_load;
   logic [RESULT_W-1:0] result [RES_N];
   logic [XZ_N-1:0]     xz_done;
   logic                any_done;
   logic                wr_guarded;
   logic                key_ok;

   assign xz_done  = {pressure_two_done, pressure_one_done, x_done};
   assign any_done = (|channel_done) | (|xz_done);
   assign res_load = {pressure_two_done, pressure_one_done, x_done, any_done};

   // Index 0 is the last result; 1 to 3 are X, first and second pressure
   for (genvar i = 0; i < RES_N; i++) begin : g_res
      result_hold #(
         .W (RESULT_W)
      ) u_hold (
         .clock (clock),
         .rst_n (rst_n),
         .load  (res_load[i]),
         .value (conv_value),
         .data  (result[i])
      );
   end

   // Event side of the sticky flags; overruns fire on a done already pending
   always_comb begin
      flag_set = '0;
      flag_set[CHANNEL_DONE_LSB +: CHAN_N]    = channel_done;
      flag_set[CHANNEL_OVERRUN_LSB +: CHAN_N] =
         channel_done & flags[CHANNEL_DONE_LSB +: CHAN_N];
      flag_set[RESULT_READY_BIT]    = any_done;
      flag_set[GENERAL_OVERRUN_BIT] = any_done & flags[RESULT_READY_BIT];
      flag_set[PEN_TOUCH_BIT]       = pen_touch;
      flag_set[PEN_LIFT_BIT]        = pen_lift;
      flag_set[XZ_DONE_LSB +: XZ_N]    = xz_done;
      flag_set[XZ_OVERRUN_LSB +: XZ_N] = xz_done & flags[XZ_DONE_LSB +: XZ_N];
   end

   // Clear side: clear on read, or a one written to the status word
   always_comb begin
      flag_clr = '0;
      if (rd_strobe) begin
         unique case (addr)
            CONVERTER_STATUS_ADDR: flag_clr = READ_CLEAR;
            LAST_RESULT_ADDR:      flag_clr[RESULT_READY_BIT] = 1'b1;
            X_POSITION_ADDR:       flag_clr[XZ_DONE_LSB] = 1'b1;
            PRESSURE_ONE_ADDR:     flag_clr[XZ_DONE_LSB + 1] = 1'b1;
            PRESSURE_TWO_ADDR:     flag_clr[XZ_DONE_LSB + 2] = 1'b1;
            default:               flag_clr = '0;
         endcase
      end
      if (wr_strobe && addr == CONVERTER_STATUS_ADDR) begin
         flag_clr = wr_data & IRQ_LAYOUT;
      end
   end

   status_flags #(
      .W (DATA_W)
   ) u_flags (
      .clock (clock),
      .rst_n (rst_n),
      .set   (flag_set & IRQ_LAYOUT),
      .clear (flag_clr),
      .flags (flags)
   );

   // Receive-counter bits are levels from the transfer logic, not sticky
   always_comb begin
      status = flags & IRQ_LAYOUT;
      status[RECEIVE_COUNT_END_BIT]  = receive_count_end;
      status[RECEIVE_BOTH_EMPTY_BIT] = receive_both_empty;
   end

   assign key_ok     = wr_data[KEY_LSB +: KEY_W] == GUARD_KEY;
   assign wr_guarded = wr_strobe && r.guard_en &&
                       (addr == CONVERTER_MODE_ADDR || addr == TRIGGER_SETUP_ADDR ||
                        addr == TOUCH_SETUP_ADDR);

   always_comb begin
      next_r = r;
      if (wr_strobe && !wr_guarded) begin
         unique case (addr)
            CONVERTER_MODE_ADDR: next_r.mode_cfg  = wr_data;
            TRIGGER_SETUP_ADDR:  next_r.trig_cfg  = wr_data;
            TOUCH_SETUP_ADDR:    next_r.touch_cfg = wr_data;
            IRQ_ENABLE_SET_ADDR:
               next_r.mask = r.mask | (wr_data & IRQ_LAYOUT);
            IRQ_ENABLE_CLEAR_ADDR:
               next_r.mask = r.mask & ~(wr_data & IRQ_LAYOUT);
            PANEL_SWITCH_ADDR:
               next_r.switches = wr_data[SWITCH_W-1:0];
            WRITE_GUARD_MODE_ADDR: begin
               if (key_ok) begin
                  next_r.guard_en = wr_data[GUARD_BIT];
               end
            end
            default: next_r.mask = r.mask;
         endcase
      end
      // Rejected write leaves the target alone and records where it went
      if (wr_guarded) begin
         next_r.err_off = ERR_W'(addr[OFFS_W-1:0]);
      end
      // Read data stand one cycle only, then fall back to zero
      next_r.rdata = '0;
      if (rd_strobe) begin
         unique case (addr)
            CONVERTER_MODE_ADDR:   next_r.rdata = r.mode_cfg;
            TRIGGER_SETUP_ADDR:    next_r.rdata = r.trig_cfg;
            TOUCH_SETUP_ADDR:      next_r.rdata = r.touch_cfg;
            CONVERTER_STATUS_ADDR: next_r.rdata = status;
            LAST_RESULT_ADDR:      next_r.rdata = DATA_W'(result[0]);
            IRQ_MASK_VIEW_ADDR:    next_r.rdata = r.mask;
            X_POSITION_ADDR:       next_r.rdata = DATA_W'(result[1]);
            PRESSURE_ONE_ADDR:     next_r.rdata = DATA_W'(result[2]);
            PRESSURE_TWO_ADDR:     next_r.rdata = DATA_W'(result[3]);
            PANEL_SWITCH_ADDR:     next_r.rdata = DATA_W'(r.switches);
            WRITE_GUARD_MODE_ADDR: next_r.rdata = DATA_W'(r.guard_en);
            WRITE_GUARD_STAT_ADDR:
               next_r.rdata = {r.err_off, 7'h00, r.guard_en};
            default:               next_r.rdata = '0;
         endcase
      end
      // Registered, so the line follows the flags one cycle late
      next_r.irq = |(status & r.mask);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rd_data        = r.rdata;
   assign converter_mode = r.mode_cfg;
   assign trigger_setup  = r.trig_cfg;
   assign touch_setup    = r.touch_cfg;
   assign x_plus_switch  = r.switches[0];
   assign x_minus_switch = r.switches[1];
   assign y_plus_switch  = r.switches[2];
   assign y_minus_switch = r.switches[3];
   assign irq            = r.irq;

   default clocking cb @(posedge clock);
   endclocking

   default disable iff (!rst_n);

   last_result_load_a: assert property (
      any_done ##1 (rd_strobe && addr == LAST_RESULT_ADDR)
      |=> rd_data == DATA_W'($past(conv_value, 2)))
      else $error("last result not loaded");

   mask_set_a: assert property (
      wr_strobe && addr == IRQ_ENABLE_SET_ADDR
      |=> r.mask == ($past(r.mask) | ($past(wr_data) & IRQ_LAYOUT)))
      else $error("enable write did not set mask");

   mask_clear_a: assert property (
      wr_strobe && addr == IRQ_ENABLE_CLEAR_ADDR
      |=> r.mask == ($past(r.mask) & ~$past(wr_data)))
      else $error("disable write did not clear mask");

   mask_hold_a: assert property (
      !(wr_strobe && (addr == IRQ_ENABLE_SET_ADDR || addr == IRQ_ENABLE_CLEAR_ADDR))
      |=> $stable(r.mask))
      else $error("mask changed without a mask write");

   mask_view_a: assert property (
      rd_strobe && addr == IRQ_MASK_VIEW_ADDR |=> rd_data == $past(r.mask))
      else $error("mask read wrong");

   result_upper_zero_a: assert property (
      rd_strobe && (addr == X_POSITION_ADDR || addr == PRESSURE_ONE_ADDR ||
                    addr == PRESSURE_TWO_ADDR)
      |=> rd_data[DATA_W-1:RESULT_W] == '0)
      else $error("result upper bits not zero");

   x_result_load_a: assert property (
      x_done ##1 (rd_strobe && addr == X_POSITION_ADDR)
      |=> rd_data == DATA_W'($past(conv_value, 2)))
      else $error("X result not loaded");

   pressure_one_load_a: assert property (
      pressure_one_done ##1 (rd_strobe && addr == PRESSURE_ONE_ADDR)
      |=> rd_data == DATA_W'($past(conv_value, 2)))
      else $error("first pressure result not loaded");

   pressure_two_load_a: assert property (
      pressure_two_done ##1 (rd_strobe && addr == PRESSURE_TWO_ADDR)
      |=> rd_data == DATA_W'($past(conv_value, 2)))
      else $error("second pressure result not loaded");

   status_layout_a: assert property (
      rd_strobe && addr == CONVERTER_STATUS_ADDR |=> (rd_data & ~IRQ_LAYOUT) == '0)
      else $error("status bit outside the shared layout");

   switch_drive_a: assert property (
      wr_strobe && addr == PANEL_SWITCH_ADDR
      |=> {y_minus_switch, y_plus_switch, x_minus_switch, x_plus_switch}
          == $past(wr_data[SWITCH_W-1:0]))
      else $error("switch command not applied");

   switch_hold_a: assert property (
      !(wr_strobe && addr == PANEL_SWITCH_ADDR) |=> $stable(r.switches))
      else $error("switches moved without a command");

   guard_key_a: assert property (
      wr_strobe && addr == WRITE_GUARD_MODE_ADDR && !key_ok
      |=> $stable(r.guard_en))
      else $error("guard bit changed without key");

   guard_reject_a: assert property (
      wr_guarded && addr == CONVERTER_MODE_ADDR |=> $stable(converter_mode))
      else $error("guarded write took effect");

   config_kept_a: assert property (
      wr_guarded |=> $stable(converter_mode) && $stable(trigger_setup) && $stable(touch_setup))
      else $error("guarded configuration write took effect");

   guard_set_a: assert property (
      wr_strobe && addr == WRITE_GUARD_MODE_ADDR && key_ok
      |=> r.guard_en == $past(wr_data[GUARD_BIT]))
      else $error("keyed guard write not applied");

   guard_status_a: assert property (
      rd_strobe && addr == WRITE_GUARD_STAT_ADDR
      |=> rd_data[GUARD_BIT] == $past(r.guard_en))
      else $error("guard status bit wrong");

   offset_capture_a: assert property (
      wr_guarded |=> r.err_off == ERR_W'($past(addr[OFFS_W-1:0])))
      else $error("rejected offset not captured");

   ready_clear_a: assert property (
      rd_strobe && addr == LAST_RESULT_ADDR && !any_done
      |=> !flags[RESULT_READY_BIT])
      else $error("ready flag not cleared by result read");

   irq_level_a: assert property (
      (|(status & r.mask)) |=> irq)
      else $error("interrupt not raised");

   irq_low_a: assert property (
      !(|(status & r.mask)) |=> !irq)
      else $error("interrupt raised with nothing pending");

   ready_set_a: assert property (
      any_done |=> flags[RESULT_READY_BIT])
      else $error("ready flag not set by a conversion");

   general_overrun_a: assert property (
      any_done && flags[RESULT_READY_BIT] |=> flags[GENERAL_OVERRUN_BIT])
      else $error("general overrun not flagged");

   read_clear_a: assert property (
      rd_strobe && addr == CONVERTER_STATUS_ADDR
      |=> (flags & READ_CLEAR & ~$past(flag_set)) == '0)
      else $error("flag survived a status read");

endmodule

`default_nettype wire

/* hdl/touch_regs_pkg.sv */
// Package for the touch-screen converter register bank.
// Assumes a 32-bit word register port; printed byte addresses are decoded whole.
`default_nettype none

package touch_regs_pkg;

   localparam int DATA_W   = 32;
   localparam int ADDR_W   = 32;
   localparam int RESULT_W = 10;
   localparam int CHAN_N   = 8;
   localparam int SWITCH_W = 4;
   localparam int KEY_W    = 24;
   localparam int ERR_W    = 24;
   localparam int OFFS_W   = 8;
   localparam int RES_N    = 4;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] CONVERTER_MODE_ADDR   = 32'hFFFB0000;
   localparam logic [ADDR_W-1:0] TRIGGER_SETUP_ADDR    = 32'hFFFB0008;
   localparam logic [ADDR_W-1:0] TOUCH_SETUP_ADDR      = 32'hFFFB000C;
   localparam logic [ADDR_W-1:0] CONVERTER_STATUS_ADDR = 32'hFFFB001C;
   localparam logic [ADDR_W-1:0] LAST_RESULT_ADDR      = 32'hFFFB0020;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_SET_ADDR   = 32'hFFFB0024;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_CLEAR_ADDR = 32'hFFFB0028;
   localparam logic [ADDR_W-1:0] IRQ_MASK_VIEW_ADDR    = 32'hFFFB002C;
   localparam logic [ADDR_W-1:0] X_POSITION_ADDR       = 32'hFFFB0050;
   localparam logic [ADDR_W-1:0] PRESSURE_ONE_ADDR     = 32'hFFFB0054;
   localparam logic [ADDR_W-1:0] PRESSURE_TWO_ADDR     = 32'hFFFB0058;
   localparam logic [ADDR_W-1:0] PANEL_SWITCH_ADDR     = 32'hFFFB0060;
   localparam logic [ADDR_W-1:0] WRITE_GUARD_MODE_ADDR = 32'hFFFB00E4;
   localparam logic [ADDR_W-1:0] WRITE_GUARD_STAT_ADDR = 32'hFFFB00E8;

   // Status, enable, disable and mask share this layout
   localparam int CHANNEL_DONE_LSB       = 0;
   localparam int CHANNEL_OVERRUN_LSB    = 8;
   localparam int RESULT_READY_BIT       = 16;
   localparam int GENERAL_OVERRUN_BIT    = 17;
   localparam int RECEIVE_COUNT_END_BIT  = 18;
   localparam int RECEIVE_BOTH_EMPTY_BIT = 19;
   localparam int PEN_TOUCH_BIT          = 20;
   localparam int PEN_LIFT_BIT           = 21;
   localparam int XZ_DONE_LSB            = 24;
   localparam int XZ_OVERRUN_LSB         = 28;
   localparam logic [DATA_W-1:0] IRQ_LAYOUT = 32'h773FFFFF;
   localparam logic [DATA_W-1:0] READ_CLEAR = 32'h7032FF00;

   // Write guard fields
   localparam int GUARD_BIT   = 0;
   localparam int KEY_LSB     = 8;
   localparam int ERR_LSB     = 8;
   localparam logic [KEY_W-1:0] GUARD_KEY = 24'h545341;

endpackage

`default_nettype wire

/* verif/conv_model.sv */
// Partner model: converter done pulses, pen events and transfer levels.
// Assumes the bench calls its tasks from one process on the bank's clock.
`default_nettype none

module conv_model
   import touch_regs_pkg::*;
(
   // Clock
   input  wire logic                clock,
   // Events
   output logic      [CHAN_N-1:0]   channel_done,
   output logic                     x_done,
   output logic                     pressure_one_done,
   output logic                     pressure_two_done,
   output logic      [RESULT_W-1:0] conv_value,
   output logic                     pen_touch,
   output logic                     pen_lift,
   // Transfer levels
   output logic                     receive_count_end,
   output logic                     receive_both_empty
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [12:0] pulse;

   assign channel_done      = pulse[7:0];
   assign x_done            = pulse[8];
   assign pressure_one_done = pulse[9];
   assign pressure_two_done = pulse[10];
   assign pen_touch         = pulse[11];
   assign pen_lift          = pulse[12];

   initial begin
      pulse              = '0;
      conv_value         = '0;
      receive_count_end  = 1'b0;
      receive_both_empty = 1'b0;
   end

   // Kind 0-7 channel, 8 X, 9 Z1, 10 Z2, 11 pen touch, 12 pen lift
   task automatic fire(input int kind, input logic [RESULT_W-1:0] v);
      @(posedge clock);
      pulse      <= 13'(1) << kind;
      conv_value <= v;
      @(posedge clock);
      pulse      <= '0;
      // Value is stale after the pulse; inverted so a late sample shows up
      conv_value <= ~v;
   endtask

   task automatic set_levels(input logic a, input logic b);
      @(posedge clock);
      receive_count_end  <= a;
      receive_both_empty <= b;
   endtask
endmodule

`default_nettype wire

/* verif/touch_regs_tb_top.sv */
// Self-checking bench for the touch converter register bank.
// Assumes the partner model drives all converter event inputs.
`default_nettype none

module touch_regs_tb_top import touch_regs_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clock;
   logic                rst_n;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   wr_data;
   logic                wr_strobe;
   logic                rd_strobe;
   logic [DATA_W-1:0]   rd_data;
   logic [CHAN_N-1:0]   channel_done;
   logic                x_done;
   logic                pressure_one_done;
   logic                pressure_two_done;
   logic [RESULT_W-1:0] conv_value;
   logic                pen_touch;
   logic                pen_lift;
   logic                receive_count_end;
   logic                receive_both_empty;
   logic [DATA_W-1:0]   converter_mode;
   logic [DATA_W-1:0]   trigger_setup;
   logic [DATA_W-1:0]   touch_setup;
   logic                x_plus_switch;
   logic                x_minus_switch;
   logic                y_plus_switch;
   logic                y_minus_switch;
   logic                irq;
   int                  n_fail;
   int                  samples_checked;
   int                  cyc;
   logic [31:0]         seed;
   logic [31:0]         d;
   logic [31:0]         mask_m;

   touch_regs dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .channel_done(channel_done), .x_done(x_done), .pressure_one_done(pressure_one_done),
      .pressure_two_done(pressure_two_done), .conv_value(conv_value),
      .pen_touch(pen_touch), .pen_lift(pen_lift), .receive_count_end(receive_count_end),
      .receive_both_empty(receive_both_empty), .converter_mode(converter_mode),
      .trigger_setup(trigger_setup), .touch_setup(touch_setup),
      .x_plus_switch(x_plus_switch), .x_minus_switch(x_minus_switch),
      .y_plus_switch(y_plus_switch), .y_minus_switch(y_minus_switch), .irq(irq));

   conv_model u_conv (.clock(clock), .channel_done(channel_done), .x_done(x_done),
      .pressure_one_done(pressure_one_done), .pressure_two_done(pressure_two_done),
      .conv_value(conv_value), .pen_touch(pen_touch), .pen_lift(pen_lift),
      .receive_count_end(receive_count_end), .receive_both_empty(receive_both_empty));

   always #10 clock = ~clock;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Settles one step past the edge so registered outputs have landed
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clock);
      wr_strobe <= 1'b1;
      addr      <= a;
      wr_data   <= v;
      @(posedge clock);
      wr_strobe <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] v);
      @(posedge clock);
      rd_strobe <= 1'b1;
      addr      <= a;
      @(posedge clock);
      rd_strobe <= 1'b0;
      #1;
      v = rd_data;
   endtask

   task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      check(name, v, exp);
   endtask

   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      addr = '0;
      wr_data = '0;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
      seed = 32'h21F0;
      mask_m = '0;
      n_fail = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rdc("mask_rst", IRQ_MASK_VIEW_ADDR, '0);
      rdc("guard_rst", WRITE_GUARD_STAT_ADDR, '0);
      rdc("unmapped", 32'hFFFB0070, '0);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         wr(i[0] ? IRQ_ENABLE_CLEAR_ADDR : IRQ_ENABLE_SET_ADDR, seed);
         mask_m = i[0] ? (mask_m & ~seed) : (mask_m | (seed & IRQ_LAYOUT));
         rdc("mask", IRQ_MASK_VIEW_ADDR, mask_m);
      end
      rdc("wo_read", IRQ_ENABLE_SET_ADDR, '0);
      wr(IRQ_ENABLE_CLEAR_ADDR, '1);
      wr(IRQ_ENABLE_SET_ADDR, 32'h1 << RESULT_READY_BIT);
      u_conv.fire(5, 10'h2A5);
      repeat (2) @(posedge clock);
      #1;
      check("irq_set", {31'h0, irq}, 32'h1);
      rd(CONVERTER_STATUS_ADDR, d);
      check("ready_set", {31'h0, d[RESULT_READY_BIT]}, 32'h1);
      rdc("last_irq", LAST_RESULT_ADDR, 32'h2A5);
      @(posedge clock);
      #1;
      check("irq_clr", {31'h0, irq}, 32'h0);
      rd(CONVERTER_STATUS_ADDR, d);
      check("ready_clr", {31'h0, d[RESULT_READY_BIT]}, 32'h0);
      u_conv.fire(1, 10'h155);
      wr(IRQ_ENABLE_CLEAR_ADDR, 32'h1 << RESULT_READY_BIT);
      @(posedge clock);
      #1;
      check("irq_masked", {31'h0, irq}, 32'h0);
      for (int k = 0; k < 11; k++) begin
         seed = xs(seed);
         u_conv.fire(k, seed[9:0]);
         rdc("last", LAST_RESULT_ADDR, {22'h0, seed[9:0]});
         if (k > 7) begin
            rdc("xz", X_POSITION_ADDR + 32'(4 * (k - 8)), {22'h0, seed[9:0]});
         end
      end
      for (int k = 11; k < 13; k++) begin
         u_conv.fire(k, '0);
         rd(CONVERTER_STATUS_ADDR, d);
         check("pen_set", {31'h0, d[PEN_TOUCH_BIT + k - 11]}, 32'h1);
         rd(CONVERTER_STATUS_ADDR, d);
         check("pen_clr", {31'h0, d[PEN_TOUCH_BIT + k - 11]}, 32'h0);
      end
      // Clear every sticky bit, then provoke a channel and a general overrun
      wr(CONVERTER_STATUS_ADDR, '1);
      rdc("w1c", CONVERTER_STATUS_ADDR, '0);
      u_conv.fire(3, 10'h0C3);
      u_conv.fire(3, 10'h13C);
      rdc("overrun_set", CONVERTER_STATUS_ADDR, 32'h0003_0808);
      rdc("overrun_clr", CONVERTER_STATUS_ADDR, 32'h0001_0008);
      rdc("last_over", LAST_RESULT_ADDR, 32'h0000_013C);
      u_conv.set_levels(1'b1, 1'b0);
      rd(CONVERTER_STATUS_ADDR, d);
      check("levels", {30'h0, d[RECEIVE_BOTH_EMPTY_BIT], d[RECEIVE_COUNT_END_BIT]}, 32'h1);
      for (int i = 0; i < 16; i++) begin
         wr(PANEL_SWITCH_ADDR, 32'(i));
         check("switch", {28'h0, y_minus_switch, y_plus_switch, x_minus_switch,
                          x_plus_switch}, 32'(i));
      end
      seed = xs(seed);
      wr(TRIGGER_SETUP_ADDR, seed);
      check("trig_open", trigger_setup, seed);
      wr(WRITE_GUARD_MODE_ADDR, {GUARD_KEY ^ 24'h1, 8'h01});
      rdc("guard_nokey", WRITE_GUARD_STAT_ADDR, '0);
      wr(WRITE_GUARD_MODE_ADDR, {GUARD_KEY, 8'h01});
      rdc("guard_on", WRITE_GUARD_STAT_ADDR, 32'h1);
      wr(CONVERTER_MODE_ADDR, ~seed);
      check("mode_kept", converter_mode, '0);
      wr(TOUCH_SETUP_ADDR, ~seed);
      check("touch_kept", touch_setup, '0);
      wr(TRIGGER_SETUP_ADDR, ~seed);
      check("trig_kept", trigger_setup, seed);
      rdc("guard_offs", WRITE_GUARD_STAT_ADDR, 32'h0000_0801);
      wr(WRITE_GUARD_MODE_ADDR, {GUARD_KEY, 8'h00});
      rdc("guard_off", WRITE_GUARD_STAT_ADDR, 32'h0000_0800);
      wr(CONVERTER_MODE_ADDR, seed);
      check("mode_open", converter_mode, seed);
      print_verdict();
   end
endmodule

`default_nettype wire
